// File: design/ppm_capability.sv
/*
  Power-management capability header and control/status register,
  reached over configuration reads and writes on the PCI clock.
  Assumes the request port is synchronous to clk and that wake events
  arrive as one-cycle pulses from logic on the same clock.
*/
// Behaviour
// - Header bit 19 reads 0: wake signalling needs no PCI clock.
// - Version field bits 18:16 reads 010b.
// - Next capability pointer bits 15:8 always reads 00h.
// - Capability identifier bits 7:0 always reads 01h.
// - A wake event sets the status flag regardless of the enable.
// - Status flag survives soft resets only with cold-wake support.
// - The enable bit allows wake output; cleared suppresses it.
// - Enable survives soft resets only with cold-wake support.
// - Data scale field is read-only zero.
// - Data select is read-write four bits, reset to zero.
// - Cold-wake support needs aux power high and the stored option.
`timescale 1ns/1ps
`default_nettype none
module ppm_capability
  import ppm_pkg::*;
#(
  parameter logic [3:0] SUPPORTED_STATES = 4'hf
)
(
  // Clock and resets.
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        por_n,
  input  wire logic        soft_reset,
  // Configuration access.
  input  wire ppm_req_s    req,
  output logic [31:0]      rdata,
  output logic             ack,
  // Straps and events.
  input  wire logic        aux_power_detect,
  input  wire logic        cold_support_option,
  input  wire logic        wake_event,
  // Status outputs.
  output logic             wake_out_n,
  output logic [1:0]       power_state,
  output logic             cold_wake_support
);

  // D0 is the reset state, so a build that cannot enter it is refused.
  if (SUPPORTED_STATES[0] != 1'b1)
  begin : g_no_d0
    $error("D0 must always be supported");
  end

  // All registers of the block but the sticky and strap bits in one word. The read data is held in a
  // register so that the answer stands for a whole cycle and does not
  // ripple with the request lines.
  typedef struct packed {
    logic [31:0] rdata;
    logic        ack;
    logic [3:0]  power_data_select;
    logic [1:0]  pstate;
    logic        wake_n;
    logic        rst_d;
  } ppm_state_s;

  ppm_state_s  st;
  ppm_state_s  next_st;
  ppm_sticky_s sticky;
  logic        cold;
  logic        hit_cs;
  logic        hit_hdr;
  logic        wr_cs;
  logic        func_reset;
  logic [31:0] hdr_word;
  logic [31:0] cs_word;

  ////////////////////////////////////////////////////////////////////////
  // Strap capture runs during hardware reset; the strap module is held
  // on the power-up reset so the result stays valid until the release.
  // Limitation: the pin passes two flip-flops first, so power-up reset
  // must end at least two cycles before hardware reset does, or the
  // strap reads low.
  ppm_strap u_strap (
    .clk                 (clk),
    .resetn              (por_n),
    .in_reset            (st.rst_d),
    .aux_power_detect    (aux_power_detect),
    .cold_support_option (cold_support_option),
    .cold_wake_support   (cold)
  );

  // Hardware reset is seen by the sticky bits as a synchronous clear.
  assign func_reset = st.rst_d | soft_reset;

  // Only the low address byte is decoded; the rest of the configuration
  // space lives elsewhere and never reaches this port.
  assign hit_cs  = (req.addr == PPM_OFF_CTRL_STAT);
  assign hit_hdr = (req.addr == PPM_OFF_CAP_HEADER);
  assign wr_cs   = req.wr & hit_cs;

  // The sticky bits sit on the power-up reset. Status and enable share
  // byte lane 1, so one lane enable qualifies both.
  ppm_sticky u_sticky (
    .clk               (clk),
    .por_n             (por_n),
    .func_reset        (func_reset),
    .cold_wake_support (cold),
    .wake_event        (wake_event),
    .clr_status        (wr_cs & req.be[1] & req.wdata[PPM_WAKE_STAT_BIT]),
    .en_we             (wr_cs & req.be[1]),
    .en_wdata          (req.wdata[PPM_WAKE_EN_BIT]),
    .sticky            (sticky)
  );

  ////////////////////////////////////////////////////////////////////////
  // Read images of both registers.
  always_comb
  begin
    hdr_word = '0;
    hdr_word[PPM_COLD_BIT] = cold;
    hdr_word[PPM_CLK_INDEP_BIT] = PPM_CLK_INDEP_VAL;
    hdr_word[PPM_REV_LSB +: 3] = PPM_REV_VAL;
    hdr_word[PPM_NEXT_LSB +: 8] = PPM_NEXT_VAL;
    hdr_word[PPM_CAPABILITY_IDENTIFIER_LSB +: 8] = PPM_CAPABILITY_IDENTIFIER_VAL;
    cs_word = '0;
    cs_word[PPM_WAKE_STAT_BIT] = sticky.wake_event_status;
    cs_word[PPM_SCALE_LSB +: 2] = PPM_SCALE_VAL;
    cs_word[PPM_POWER_DATA_SELECT_LSB +: 4] = st.power_data_select;
    cs_word[PPM_WAKE_EN_BIT] = sticky.wake_signal_enable;
    cs_word[PPM_PSTATE_LSB +: 2] = st.pstate;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register updates. Every access is acknowledged one cycle later,
  // including unmapped ones, which read zero.
  always_comb
  begin
    next_st = st;
    next_st.rst_d = 1'b0;
    next_st.ack = req.rd | req.wr;
    next_st.rdata = '0;
    if (req.rd && hit_hdr)
    begin
      next_st.rdata = hdr_word;
    end
    else if (req.rd && hit_cs)
    begin
      next_st.rdata = cs_word;
    end
    if (soft_reset)
    begin
      next_st.power_data_select = PPM_POWER_DATA_SELECT_RST;
      next_st.pstate = PPM_D0;
    end
    else if (wr_cs)
    begin
      if (req.be[1])
      begin
        next_st.power_data_select = req.wdata[PPM_POWER_DATA_SELECT_LSB +: 4];
      end
      if (req.be[0] && SUPPORTED_STATES[req.wdata[1:0]])
      begin
        next_st.pstate = req.wdata[PPM_PSTATE_LSB +: 2];
      end
    end
    // The output follows the registered sticky bits one cycle later.
    next_st.wake_n = ~(sticky.wake_event_status
                       & sticky.wake_signal_enable);
  end

  // Hardware reset returns every field to its default and raises the
  // reset marker, which clears the sticky bits on every edge while it is
  // high, up to the first edge after release, unless cold wake is supported.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st        <= '0;
      st.rst_d  <= 1'b1;
      st.wake_n <= 1'b1;
      st.pstate <= PPM_D0;
      st.power_data_select   <= PPM_POWER_DATA_SELECT_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Every output comes straight from a flip-flop.
  assign rdata             = st.rdata;
  assign ack               = st.ack;
  assign wake_out_n        = st.wake_n;
  assign power_state       = st.pstate;
  assign cold_wake_support = cold;

  ////////////////////////////////////////////////////////////////////////
  // Checks. Properties on the sticky bits are disabled only by the
  // power-up reset, because those bits must ride through hardware reset.

  // Both halves of the wake condition, and an event that completes it
  // with no write or reset getting in the way.
  sequence s_both_set;
    sticky.wake_event_status && sticky.wake_signal_enable;
  endsequence

  sequence s_event_armed;
    wake_event && sticky.wake_signal_enable && !func_reset && !wr_cs;
  endsequence

  // The pin lags the sticky bits by one register stage.
  sequence s_pin_low_late;
    ##1 !wake_out_n;
  endsequence

  sequence s_access;
    req.rd || req.wr;
  endsequence

  // The header is a constant image apart from the strap bit.
  AST_HDR_CONST: assert property (
    @(posedge clk) disable iff (!resetn)
    req.rd && hit_hdr |=> rdata[19:0] == 20'h20001)
    else $error("capability header fields wrong");

  AST_HDR_COLD: assert property (
    @(posedge clk) disable iff (!resetn)
    req.rd && hit_hdr |=> rdata[PPM_COLD_BIT] == $past(cold))
    else $error("header cold-wake bit wrong");

  // Every access completes on the bus, refused ones included.
  AST_ACK: assert property (
    @(posedge clk) disable iff (!resetn)
    s_access |=> ack)
    else $error("access not acknowledged");

  // Status flag: set by events, cleared by a one, kept by a zero.
  AST_EVENT_SETS: assert property (
    @(posedge clk) disable iff (!por_n)
    wake_event |=> sticky.wake_event_status)
    else $error("wake event did not set status");

  AST_W1C: assert property (
    @(posedge clk) disable iff (!por_n)
    wr_cs && req.be[1] && req.wdata[15] && !wake_event && !func_reset
    |=> !sticky.wake_event_status)
    else $error("write one did not clear status");

  AST_W0_KEEP: assert property (
    @(posedge clk) disable iff (!por_n)
    wr_cs && !req.wdata[15] && !func_reset && sticky.wake_event_status
    |=> sticky.wake_event_status)
    else $error("write zero changed status");

  // Soft and hardware resets keep the sticky bits only with cold wake.
  AST_SOFT_KEEP: assert property (
    @(posedge clk) disable iff (!por_n)
    soft_reset && cold && sticky.wake_signal_enable && !wr_cs
    |=> sticky.wake_signal_enable)
    else $error("sticky enable lost on soft reset");

  AST_HW_CLEAR: assert property (
    @(posedge clk) disable iff (!por_n)
    st.rst_d && !cold && !wake_event
    |=> !sticky.wake_signal_enable && !sticky.wake_event_status)
    else $error("sticky bits kept without cold wake");

  // Wake output tracks status and enable one cycle late.
  AST_PIN: assert property (
    @(posedge clk) disable iff (!resetn)
    s_both_set |=> !wake_out_n)
    else $error("wake output not asserted");

  AST_PIN_OFF: assert property (
    @(posedge clk) disable iff (!resetn)
    !sticky.wake_signal_enable |=> wake_out_n)
    else $error("wake output asserted while disabled");

  AST_WAKE_PATH: assert property (
    @(posedge clk) disable iff (!resetn || !por_n)
    s_event_armed |=> s_pin_low_late)
    else $error("wake event did not reach the output");

  // Data scale reads zero; data select stores what the host writes.
  AST_SCALE: assert property (
    @(posedge clk) disable iff (!resetn)
    req.rd && hit_cs |=> rdata[14:13] == 2'h0)
    else $error("data scale nonzero");

  AST_POWER_DATA_SELECT: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_cs && req.be[1] && !soft_reset
    |=> st.power_data_select == $past(req.wdata[PPM_POWER_DATA_SELECT_LSB +: 4]))
    else $error("data select not stored");

  // Power state: supported codes land, others leave it alone, and a
  // soft reset returns to D0 with data select cleared.
  AST_PSTATE: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_cs && req.be[0] && !soft_reset
    && SUPPORTED_STATES[req.wdata[1:0]]
    |=> power_state == $past(req.wdata[1:0]))
    else $error("power state not taken");

  AST_BAD_STATE: assert property (
    @(posedge clk) disable iff (!resetn)
    wr_cs && !soft_reset && !SUPPORTED_STATES[req.wdata[1:0]]
    |=> $stable(power_state) && ack)
    else $error("unsupported state accepted");

  AST_SOFT_DEFAULTS: assert property (
    @(posedge clk) disable iff (!resetn)
    soft_reset |=> power_state == PPM_D0 && st.power_data_select == PPM_POWER_DATA_SELECT_RST)
    else $error("soft reset left power state or data select");

  // Cold-wake support needs the stored option, and it is frozen once
  // hardware reset is over.
  AST_COLD: assert property (
    @(posedge clk) disable iff (!por_n)
    !cold_support_option && st.rst_d |=> !cold)
    else $error("cold support set without option");

  AST_COLD_HOLD: assert property (
    @(posedge clk) disable iff (!por_n)
    !st.rst_d |=> $stable(cold))
    else $error("cold support changed outside reset");

endmodule
`default_nettype wire

// File: design/ppm_pkg.sv
/*
  Package for the power-management capability block: register offsets,
  field positions, reset values, power-state codes and carrier structs.
  Assumes a configuration-access port on the PCI clock.
*/
package ppm_pkg;

  // Configuration offsets of the two registers.
  localparam logic [7:0] PPM_OFF_CAP_HEADER = 8'hc0;
  localparam logic [7:0] PPM_OFF_CTRL_STAT  = 8'hc4;

  // Header fields, all read-only.
  localparam int         PPM_CLK_INDEP_BIT  = 19;
  localparam logic       PPM_CLK_INDEP_VAL  = 1'b0;
  localparam int         PPM_REV_LSB        = 16;
  localparam logic [2:0] PPM_REV_VAL        = 3'h2;
  localparam int         PPM_NEXT_LSB       = 8;
  localparam logic [7:0] PPM_NEXT_VAL       = 8'h00;
  localparam int         PPM_CAPABILITY_IDENTIFIER_LSB      = 0;
  localparam logic [7:0] PPM_CAPABILITY_IDENTIFIER_VAL      = 8'h01;
  localparam int         PPM_COLD_BIT       = 31;

  // Control/status fields.
  localparam int         PPM_WAKE_STAT_BIT  = 15;
  localparam int         PPM_SCALE_LSB      = 13;
  localparam logic [1:0] PPM_SCALE_VAL      = 2'h0;
  localparam int         PPM_POWER_DATA_SELECT_LSB       = 9;
  localparam logic [3:0] PPM_POWER_DATA_SELECT_RST       = 4'h0;
  localparam int         PPM_WAKE_EN_BIT    = 8;
  localparam int         PPM_PSTATE_LSB     = 0;

  // Power states.
  typedef enum logic [1:0] {
    PPM_D0   = 2'h0,
    PPM_D1   = 2'h1,
    PPM_D2   = 2'h2,
    PPM_D3H  = 2'h3
  } ppm_pstate_e;

  // Configuration access request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } ppm_req_s;

  // Sticky wake state, held on the power-up reset domain.
  typedef struct packed {
    logic wake_event_status;
    logic wake_signal_enable;
  } ppm_sticky_s;

endpackage

// File: design/ppm_sticky.sv
/*
  Wake status and wake enable bits. They live on the power-up reset and
  clear on hardware or software reset only when cold wake is absent.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_sticky
  import ppm_pkg::*;
(
  // Clock and power-up reset.
  input  wire logic  clk,
  input  wire logic  por_n,
  // Soft clearing request and cold-wake support.
  input  wire logic  func_reset,
  input  wire logic  cold_wake_support,
  // Events and writes.
  input  wire logic  wake_event,
  input  wire logic  clr_status,
  input  wire logic  en_we,
  input  wire logic  en_wdata,
  // State.
  output var ppm_sticky_s sticky
);

  ppm_sticky_s st;
  ppm_sticky_s next_st;

  ////////////////////////////////////////////////////////////////////////
  // A new event beats a simultaneous clear so no wake is lost.
  always_comb
  begin
    next_st = st;
    if (func_reset && !cold_wake_support)
    begin
      next_st = '0;
    end
    else
    begin
      if (clr_status)
      begin
        next_st.wake_event_status = 1'b0;
      end
      if (en_we)
      begin
        next_st.wake_signal_enable = en_wdata;
      end
    end
    if (wake_event)
    begin
      next_st.wake_event_status = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge por_n)
  begin
    if (!por_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sticky = st;

endmodule
`default_nettype wire

// File: design/ppm_strap.sv
/*
  Catches the auxiliary-power detect pin during reset and derives the
  cold-wake support bit. Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_strap
  import ppm_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic in_reset,
  // Strap sources.
  input  wire logic aux_power_detect,
  input  wire logic cold_support_option,
  // Result.
  output logic      cold_wake_support
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic cold;
  } ppm_strap_s;

  ppm_strap_s st;
  ppm_strap_s next_st;

  ////////////////////////////////////////////////////////////////////////
  // Sampling continues while reset is active, so the last value before
  // release is kept. A low pin forces the bit to zero.
  always_comb
  begin
    next_st    = st;
    next_st.s1 = aux_power_detect;
    next_st.s2 = st.s1;
    if (in_reset)
    begin
      next_st.cold = st.s2 & cold_support_option;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cold_wake_support = st.cold;

endmodule
`default_nettype wire

// File: verif/ppm_host_model.sv
/*
  Host-side model of the configuration requester for the power-management
  capability block. Assumes requests are taken on a rising edge of clk and
  answered, with ack and read data, exactly one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module ppm_host_model
  import ppm_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // Configuration access.
  output var ppm_req_s     req,
  input  wire logic [31:0] rdata,
  input  wire logic        ack
);

  ////////////////////////////////////////////////////////////////////////////
  // The bus is idle at time zero so no request is seen during reset.
  initial req = '0;

  // One access: the request stands for one edge, the answer is taken in the
  // following cycle. Idle address and data are inverted so a block that
  // latches them late sees a wrong value rather than a stale right one.
  task automatic access(
    input  logic        w,
    input  logic [7:0]  a,
    input  logic [3:0]  be,
    input  logic [31:0] d,
    output logic [31:0] q,
    output logic        ok
  );
  begin
    @(posedge clk);
    #1;
    req = '{rd: !w, wr: w, addr: a, be: be, wdata: d};
    @(posedge clk);
    #1;
    req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
    q   = rdata;
    ok  = ack;
  end
  endtask
endmodule
`default_nettype wire

// File: verif/test_pci_power_mgmt_capability.sv
/*
  Self-checking testbench for the power-management capability block.
  Assumes the host model issues the accesses and that only the D2 state
  is left unsupported here, so refused power-state writes are exercised.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
      num_errors++; \
    end \
  end
module test_pci_power_mgmt_capability;
  import ppm_pkg::*;

  localparam logic [3:0] SUP = 4'hb;

  logic        clk, resetn, por_n, soft_reset, aux, opt, wake_event;
  ppm_req_s    req;
  logic [31:0] rdata, q;
  logic        ack, ok, wake_out_n, cold_wake_support;
  logic [1:0]  power_state, exp_ps;
  int          num_errors = 0;
  int          checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and host model.
  ppm_capability #(.SUPPORTED_STATES(SUP)) u_ppm_capability (
    .clk(clk), .resetn(resetn), .por_n(por_n), .soft_reset(soft_reset),
    .req(req), .rdata(rdata), .ack(ack), .aux_power_detect(aux),
    .cold_support_option(opt), .wake_event(wake_event),
    .wake_out_n(wake_out_n), .power_state(power_state),
    .cold_wake_support(cold_wake_support));
  ppm_host_model u_ppm_host_model (
    .clk(clk), .req(req), .rdata(rdata), .ack(ack));

  // Clock at 250 MHz.
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and stimulus tasks.
  task automatic wr(input logic [7:0] a, input logic [3:0] be,
                    input logic [31:0] d);
    u_ppm_host_model.access(1'b1, a, be, d, q, ok);
    `CHK(ok, 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    u_ppm_host_model.access(1'b0, a, 4'h0, 32'h0, q, ok);
    `CHK(ok, 1'b1);
    `CHK(q & m, e);
  endtask

  // Power-up reset also clears the sticky bits and the strap.
  task automatic do_reset(input logic por);
    resetn = 1'b0;
    por_n  = !por;
    repeat (10) @(posedge clk);
    #1;
    resetn = 1'b1;
    por_n  = 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask

  // The wake output lags status and enable by a register stage.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // A hang is cut short and counted.
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // Main sequence.
  initial
  begin
    clk = 0; resetn = 0; por_n = 0; soft_reset = 0;
    aux = 0; opt = 0; wake_event = 0;
    do_reset(1'b1);
    rd(8'hc0, 32'h800fffff, 32'h00020001);
    wr(8'hc0, 4'hf, 32'hffffffff);
    rd(8'hc0, 32'h800fffff, 32'h00020001);
    rd(8'hc4, 32'hffffffff, 32'h0);
    rd(8'h80, 32'hffffffff, 32'h0);
    pulse(wake_event);
    settle();
    `CHK(wake_out_n, 1'b1);
    rd(8'hc4, 32'hffffffff, 32'h8000);
    wr(8'hc4, 4'h2, 32'h0100);
    settle();
    `CHK(wake_out_n, 1'b0);
    rd(8'hc4, 32'hffffffff, 32'h8100);
    wr(8'hc4, 4'h2, 32'h8100);
    settle();
    `CHK(wake_out_n, 1'b1);
    wr(8'hc4, 4'h2, 32'h7f00);
    rd(8'hc4, 32'hffffffff, 32'h1f00);
    exp_ps = 2'h0;
    for (int s = 0; s < 4; s++)
    begin
      wr(8'hc4, 4'h1, {30'h0, 2'(s)});
      if (SUP[s])
        exp_ps = 2'(s);
      `CHK(power_state, exp_ps);
      rd(8'hc4, 32'h3, {30'h0, exp_ps});
    end
    pulse(soft_reset);
    rd(8'hc4, 32'hffffffff, 32'h0);
    aux = 1'b1;
    opt = 1'b1;
    do_reset(1'b0);
    `CHK(cold_wake_support, 1'b1);
    rd(8'hc0, 32'h800fffff, 32'h80020001);
    wr(8'hc4, 4'h2, 32'h0100);
    pulse(wake_event);
    pulse(soft_reset);
    rd(8'hc4, 32'hffffffff, 32'h8100);
    do_reset(1'b0);
    rd(8'hc4, 32'hffffffff, 32'h8100);
    settle();
    `CHK(wake_out_n, 1'b0);
    aux = 1'b0;
    do_reset(1'b1);
    rd(8'hc4, 32'hffffffff, 32'h0);
    `CHK(cold_wake_support, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
